// >>> inc/cssc_pkg.sv
package cssc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CLOCK_MODE = 8'h00;
  localparam logic [7:0] ADDR_XTAL_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_MISC_CTRL  = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0c;
  localparam logic [7:0] ADDR_WDT_KICK   = 8'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CM_SRC_HI   = 7;
  localparam int CM_SRC_LO   = 5;
  localparam int CM_HF_EN    = 4;
  localparam int CM_LF_EN    = 2;
  localparam int CM_WDT_EN   = 1;
  localparam int CM_XRST_EN  = 0;
  localparam int XC_EN       = 7;
  localparam int XC_BAND_HI  = 6;
  localparam int XC_BAND_LO  = 5;
  localparam int MC_LVR_OFF  = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CLOCK_MODE_RST = 8'h96;
  localparam logic [7:0] XTAL_CTRL_RST  = 8'h00;
  localparam logic [7:0] MISC_CTRL_RST  = 8'h00;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_HF_DIV4 = 3'h0;
  localparam logic [2:0] SRC_HF_DIV2 = 3'h1;
  localparam logic [2:0] SRC_HF      = 3'h2;
  localparam logic [2:0] SRC_XTAL    = 3'h3;
  localparam logic [2:0] SRC_LF      = 3'h4;
  localparam logic [1:0] BAND_LOW    = 2'h1;
  localparam logic [1:0] BAND_MID    = 2'h2;
  localparam logic [1:0] BAND_HIGH   = 2'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int HF_HALF_NS     = 50;
  localparam int LF_HALF_NS     = 9000;
  localparam int HF_HALF_CYC    = (HF_HALF_NS / CLK_PERIOD_NS < 1) ? 1
                                  : HF_HALF_NS / CLK_PERIOD_NS;
  localparam int LF_HALF_CYC    = LF_HALF_NS / CLK_PERIOD_NS;
  localparam int XTAL_STABLE_EDGES = 1024;
  localparam int WDT_LF_PERIODS    = 8192;
  localparam logic [2:0] LVR_SEL_RST = 3'h7;

  typedef struct packed {
    logic hf;
    logic hf_div2;
    logic hf_div4;
    logic xtal;
    logic lf;
  } cssc_osc_t;

endpackage

// >>> rtl/cssc_sync.sv
`timescale 1ns/1ps
module cssc_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_async,
  output logic      o_sync
);
  logic stage1;

  // stage1 is read by the second flop only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // cssc_sync

// >>> rtl/cssc_osc_model.sv
`timescale 1ns/1ps
module cssc_osc_model #(
  parameter int HALF_CYC = 1
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_enable,
  output logic      o_tick,
  output logic      o_level
);
  logic [15:0] count;

  // a stopped oscillator freezes its level, it does not return low
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count   <= 16'h0000;
      o_tick  <= 1'b0;
      o_level <= 1'b0;
    end else if (!i_enable) begin
      o_tick  <= 1'b0;
    end else if (count >= 16'(HALF_CYC - 1)) begin
      count   <= 16'h0000;
      o_tick  <= 1'b1;
      o_level <= ~o_level;
    end else begin
      count   <= count + 16'h0001;
      o_tick  <= 1'b0;
    end
  end
endmodule // cssc_osc_model

// >>> rtl/cssc_clock_control.sv
`timescale 1ns/1ps
module cssc_clock_control #(
  parameter int         WDT_LF_PERIODS = cssc_pkg::WDT_LF_PERIODS,
  parameter logic [2:0] LVR_SEL        = cssc_pkg::LVR_SEL_RST
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // axi4-lite slave
  input  wire logic [7:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [7:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  // pins and core status
  input  wire logic        i_crystal_pin_a,
  input  wire logic        i_reset_capable_pin,
  input  wire logic        i_reset_pin_is_input,
  input  wire logic        i_supply_low,
  input  wire logic        i_power_on_done,
  input  wire logic        i_halt_exe,
  input  wire logic        i_halt_sys,
  input  wire logic        i_calibration_routine,
  // outputs
  output logic             o_crystal_enable,
  output logic [1:0]       o_crystal_band,
  output logic             o_sys_clk,
  output logic             o_external_reset,
  output logic             o_watchdog_reset,
  output logic             o_low_voltage_reset,
  output logic [2:0]       o_lvr_level
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic xtal_pin_s;
  logic rst_pin_s;
  logic supply_low_s;

  cssc_sync u_sync_xtal (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_async (i_crystal_pin_a),
    .o_sync  (xtal_pin_s)
  );

  cssc_sync u_sync_rst (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_async (i_reset_capable_pin),
    .o_sync  (rst_pin_s)
  );

  cssc_sync u_sync_lvr (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_async (i_supply_low),
    .o_sync  (supply_low_s)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] clock_mode_select;
  logic [7:0] crystal_osc_control;
  logic [7:0] misc_control;
  logic       wdt_enable;
  logic       wdt_kick;
  logic       xtal_stable;
  logic       switch_busy;
  logic [2:0] cur_src;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic       wr_take;
  logic       wr_fire;
  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic       wr_lane0;
  logic       wr_mapped;

  // address and data are taken together once both are offered
  assign wr_take = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_awready & ~o_s_axi_bvalid;
  assign wr_fire = o_s_axi_awready;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
      wr_addr         <= 8'h00;
      wr_byte         <= 8'h00;
      wr_lane0        <= 1'b0;
    end else begin
      o_s_axi_awready <= wr_take;
      o_s_axi_wready  <= wr_take;
      if (wr_take) begin
        wr_addr  <= i_s_axi_awaddr;
        wr_byte  <= i_s_axi_wdata[7:0];
        wr_lane0 <= i_s_axi_wstrb[0];
      end
    end
  end

  always_comb begin
    if (wr_addr == cssc_pkg::ADDR_CLOCK_MODE) begin
      wr_mapped = 1'b1;
    end else if (wr_addr == cssc_pkg::ADDR_XTAL_CTRL) begin
      wr_mapped = 1'b1;
    end else if (wr_addr == cssc_pkg::ADDR_MISC_CTRL) begin
      wr_mapped = 1'b1;
    end else if (wr_addr == cssc_pkg::ADDR_STATUS) begin
      wr_mapped = 1'b1;
    end else if (wr_addr == cssc_pkg::ADDR_WDT_KICK) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= cssc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      o_s_axi_bvalid <= 1'b1;
      o_s_axi_bresp  <= wr_mapped ? cssc_pkg::RESP_OKAY : cssc_pkg::RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      o_s_axi_bvalid <= 1'b0;
    end
  end

  // one write changes the whole byte at once; the switcher and the
  // oscillators see selection and enables in the same cycle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_mode_select   <= cssc_pkg::CLOCK_MODE_RST;
      crystal_osc_control <= cssc_pkg::XTAL_CTRL_RST;
      misc_control        <= cssc_pkg::MISC_CTRL_RST;
    end else begin
      if (wr_fire && wr_lane0) begin
        if (wr_addr == cssc_pkg::ADDR_CLOCK_MODE) begin
          clock_mode_select <= wr_byte;
        end else if (wr_addr == cssc_pkg::ADDR_XTAL_CTRL) begin
          crystal_osc_control <= wr_byte & 8'he0;
        end else if (wr_addr == cssc_pkg::ADDR_MISC_CTRL) begin
          misc_control <= wr_byte & 8'h04;
        end
      end
      // calibration wins over a write in the same cycle
      if (i_calibration_routine) begin
        clock_mode_select[cssc_pkg::CM_WDT_EN] <= 1'b0;
      end
    end
  end

  assign wdt_kick = wr_fire & wr_lane0 & (wr_addr == cssc_pkg::ADDR_WDT_KICK);

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [7:0] rd_value;
  logic       rd_mapped;
  logic       rd_take;

  assign rd_take = i_s_axi_arvalid & ~o_s_axi_arready & ~o_s_axi_rvalid;

  always_comb begin
    rd_mapped = 1'b1;
    if (i_s_axi_araddr == cssc_pkg::ADDR_CLOCK_MODE) begin
      rd_value = clock_mode_select;
    end else if (i_s_axi_araddr == cssc_pkg::ADDR_XTAL_CTRL) begin
      rd_value = crystal_osc_control;
    end else if (i_s_axi_araddr == cssc_pkg::ADDR_MISC_CTRL) begin
      rd_value = misc_control;
    end else if (i_s_axi_araddr == cssc_pkg::ADDR_STATUS) begin
      rd_value = {1'b0, cur_src, o_low_voltage_reset, wdt_enable, switch_busy, xtal_stable};
    end else if (i_s_axi_araddr == cssc_pkg::ADDR_WDT_KICK) begin
      rd_value = 8'h00;
    end else begin
      rd_value  = 8'h00;
      rd_mapped = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= cssc_pkg::RESP_OKAY;
    end else begin
      o_s_axi_arready <= rd_take;
      if (rd_take) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata  <= {24'h00_0000, rd_value};
        o_s_axi_rresp  <= rd_mapped ? cssc_pkg::RESP_OKAY : cssc_pkg::RESP_SLVERR;
      end else if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // oscillators
  // ----------------------------------------------------------------
  cssc_pkg::cssc_osc_t osc;
  logic                hf_tick;
  logic                hf_level;
  logic                lf_tick;
  logic [1:0]          hf_div;

  cssc_osc_model #(.HALF_CYC(cssc_pkg::HF_HALF_CYC)) u_hf_osc (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n),
    .i_enable (clock_mode_select[cssc_pkg::CM_HF_EN]),
    .o_tick   (hf_tick),
    .o_level  (hf_level)
  );

  cssc_osc_model #(.HALF_CYC(cssc_pkg::LF_HALF_CYC)) u_lf_osc (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n),
    .i_enable (clock_mode_select[cssc_pkg::CM_LF_EN]),
    .o_tick   (lf_tick),
    .o_level  (osc.lf)
  );

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      hf_div <= 2'h0;
    end else if (hf_tick && !hf_level) begin
      hf_div <= hf_div + 2'h1;
    end
  end

  assign osc.hf      = hf_level;
  assign osc.hf_div2 = hf_div[0];
  assign osc.hf_div4 = hf_div[1];
  // crystal waveform only counts while the oscillator is enabled
  assign osc.xtal    = xtal_pin_s & crystal_osc_control[cssc_pkg::XC_EN];

  // ----------------------------------------------------------------
  // crystal supervision
  // ----------------------------------------------------------------
  logic        xtal_prev;
  logic [10:0] xtal_edges;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_prev   <= 1'b0;
      xtal_edges  <= 11'h000;
      xtal_stable <= 1'b0;
    end else begin
      xtal_prev <= osc.xtal;
      if (!crystal_osc_control[cssc_pkg::XC_EN]) begin
        xtal_edges  <= 11'h000;
        xtal_stable <= 1'b0;
      end else if (osc.xtal && !xtal_prev && !xtal_stable) begin
        xtal_edges <= xtal_edges + 11'h001;
        if (xtal_edges == 11'(cssc_pkg::XTAL_STABLE_EDGES - 1)) begin
          xtal_stable <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_crystal_enable <= 1'b0;
      o_crystal_band   <= 2'h0;
    end else begin
      o_crystal_enable <= crystal_osc_control[cssc_pkg::XC_EN];
      o_crystal_band   <= crystal_osc_control[cssc_pkg::XC_BAND_HI:cssc_pkg::XC_BAND_LO];
    end
  end

  // ----------------------------------------------------------------
  // glitch-free source switch
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CSSC_RUN, CSSC_DRAIN, CSSC_ARM} cssc_sw_t;

  cssc_sw_t   sw_state;
  logic [2:0] req_src;
  logic [2:0] new_src;
  logic       old_level;
  logic       old_prev;
  logic       new_level;

  function automatic logic src_level(input cssc_pkg::cssc_osc_t o, input logic [2:0] s);
    if (s == cssc_pkg::SRC_HF_DIV4) begin
      return o.hf_div4;
    end else if (s == cssc_pkg::SRC_HF_DIV2) begin
      return o.hf_div2;
    end else if (s == cssc_pkg::SRC_HF) begin
      return o.hf;
    end else if (s == cssc_pkg::SRC_XTAL) begin
      return o.xtal;
    end else begin
      return o.lf;
    end
  endfunction

  assign req_src   = clock_mode_select[cssc_pkg::CM_SRC_HI:cssc_pkg::CM_SRC_LO];
  assign old_level = src_level(osc, cur_src);
  assign new_level = src_level(osc, new_src);
  assign switch_busy = (sw_state != CSSC_RUN);

  // the old source must show a falling edge before the gate closes; if
  // it was stopped by the same write it never does and the core hangs
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_state <= CSSC_RUN;
      cur_src  <= cssc_pkg::SRC_LF;
      new_src  <= cssc_pkg::SRC_LF;
      old_prev <= 1'b0;
    end else begin
      old_prev <= old_level;
      case (sw_state)
        CSSC_RUN: begin
          if (req_src != cur_src) begin
            new_src  <= req_src;
            sw_state <= CSSC_DRAIN;
          end
        end
        CSSC_DRAIN: begin
          if (old_prev && !old_level) begin
            sw_state <= CSSC_ARM;
          end
        end
        CSSC_ARM: begin
          if (!new_level) begin
            cur_src  <= new_src;
            sw_state <= CSSC_RUN;
          end
        end
        default: begin
          sw_state <= CSSC_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sys_clk <= 1'b0;
    end else if (sw_state == CSSC_ARM) begin
      o_sys_clk <= 1'b0;
    end else if (sw_state == CSSC_DRAIN && old_prev && !old_level) begin
      o_sys_clk <= 1'b0;
    end else begin
      o_sys_clk <= old_level;
    end
  end

  // ----------------------------------------------------------------
  // external reset pin
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_external_reset <= 1'b0;
    end else begin
      o_external_reset <= clock_mode_select[cssc_pkg::CM_XRST_EN] & i_reset_pin_is_input
                          & ~rst_pin_s;
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  logic [31:0] wdt_count;
  logic        lf_rise;

  assign lf_rise    = lf_tick & osc.lf;
  assign wdt_enable = clock_mode_select[cssc_pkg::CM_WDT_EN];

  // calibration clears the enable; reuse of the write port keeps one driver
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_count        <= 32'h0000_0000;
      o_watchdog_reset <= 1'b0;
    end else begin
      o_watchdog_reset <= 1'b0;
      if (!wdt_enable || wdt_kick) begin
        wdt_count <= 32'h0000_0000;
      end else if (lf_rise) begin
        if (wdt_count == 32'(WDT_LF_PERIODS - 1)) begin
          wdt_count        <= 32'h0000_0000;
          o_watchdog_reset <= 1'b1;
        end else begin
          wdt_count <= wdt_count + 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // low-voltage reset
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_low_voltage_reset <= 1'b0;
      o_lvr_level         <= cssc_pkg::LVR_SEL_RST;
    end else begin
      o_lvr_level         <= LVR_SEL;
      o_low_voltage_reset <= supply_low_s & i_power_on_done
                             & ~misc_control[cssc_pkg::MC_LVR_OFF]
                             & ~i_halt_exe & ~i_halt_sys;
    end
  end

endmodule // cssc_clock_control

// >>> bench/cssc_crystal_model.sv
`timescale 1ns/1ps
module cssc_crystal_model #(
  parameter int HALF = 2
) (
  input  wire logic i_clk,
  input  wire logic i_enable,
  output logic      o_pin
);
  int cnt = 0;
  initial o_pin = 1'h0;
  // an undriven resonator pin wanders, so a stale level never passes for a stable one
  always @(posedge i_clk) begin
    if (!i_enable) begin
      o_pin <= ~o_pin;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      o_pin <= ~o_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // cssc_crystal_model

// >>> bench/cssc_clock_control_properties.sv
`timescale 1ns/1ps
module cssc_clock_control_properties #(
  parameter logic [2:0] LVR_SEL = 3'h7
) (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [7:0]  i_s_axi_awaddr,
  input wire logic        i_s_axi_awvalid,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0]  i_s_axi_wstrb,
  input wire logic        i_s_axi_wvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_arvalid,
  input wire logic        i_power_on_done,
  input wire logic        i_halt_exe,
  input wire logic        i_halt_sys,
  input wire logic        o_s_axi_awready,
  input wire logic        o_s_axi_wready,
  input wire logic        o_s_axi_bvalid,
  input wire logic        o_s_axi_arready,
  input wire logic [31:0] o_s_axi_rdata,
  input wire logic        o_s_axi_rvalid,
  input wire logic        o_crystal_enable,
  input wire logic [1:0]  o_crystal_band,
  input wire logic        o_watchdog_reset,
  input wire logic        o_low_voltage_reset,
  input wire logic [2:0]  o_lvr_level
);
  // the core releases its own reset two edges late and registers outputs once more
  logic [2:0] settle;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) settle <= 3'h0;
    else if (settle != 3'h4) settle <= settle + 3'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n || settle != 3'h4);
  logic       wtake;
  logic       xtake;
  logic [2:0] wbits;
  assign wtake = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_awready && !o_s_axi_bvalid;
  assign xtake = wtake && i_s_axi_awaddr == cssc_pkg::ADDR_XTAL_CTRL && i_s_axi_wstrb[0];
  // the payload is gone from the bus by the time the output moves, so keep a copy
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) wbits <= 3'h0;
    else if (wtake) wbits <= i_s_axi_wdata[7:5];
  end
  lvr_level_a: assert property (o_lvr_level == LVR_SEL)
    else $error("threshold code differs from build value");
  halt_lvr_a: assert property ((i_halt_exe || i_halt_sys) [*3] |-> !o_low_voltage_reset)
    else $error("low-voltage reset acted in halt");
  por_lvr_a: assert property ((!i_power_on_done) [*3] |-> !o_low_voltage_reset)
    else $error("low-voltage reset before power-on done");
  xtal_enable_a: assert property (xtake |-> ##3 o_crystal_enable == wbits[2])
    else $error("crystal enable does not follow bit seven");
  xtal_band_a: assert property (xtake |-> ##3 o_crystal_band == wbits[1:0])
    else $error("crystal band does not follow bits six to five");
  write_resp_a: assert property (wtake |-> ##2 o_s_axi_bvalid)
    else $error("write response late");
  wready_pair_a: assert property (o_s_axi_wready == o_s_axi_awready)
    else $error("write data and address accepted apart");
  bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write response dropped early");
  read_resp_a: assert property (i_s_axi_arvalid && !o_s_axi_arready && !o_s_axi_rvalid
    |=> o_s_axi_rvalid && o_s_axi_arready && o_s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or upper bytes set");
  wdog_pulse_a: assert property (o_watchdog_reset |=> !o_watchdog_reset)
    else $error("watchdog reset longer than one cycle");
endmodule // cssc_clock_control_properties

bind cssc_clock_control cssc_clock_control_properties #(.LVR_SEL(LVR_SEL)) u_props (
  .i_clk, .i_reset_n, .i_s_axi_awaddr, .i_s_axi_awvalid, .i_s_axi_wdata, .i_s_axi_wstrb,
  .i_s_axi_wvalid, .i_s_axi_bready, .i_s_axi_arvalid, .i_power_on_done, .i_halt_exe,
  .i_halt_sys, .o_s_axi_awready, .o_s_axi_wready, .o_s_axi_bvalid, .o_s_axi_arready,
  .o_s_axi_rdata, .o_s_axi_rvalid, .o_crystal_enable, .o_crystal_band, .o_watchdog_reset,
  .o_low_voltage_reset, .o_lvr_level);

// >>> bench/clock_source_switch_control_test.sv
`timescale 1ns/1ps
module clock_source_switch_control_test;
  logic        i_clk = 1'h0, i_reset_n = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, pin = 1'h1, pin_in = 1'h0, sup_low = 1'h0;
  logic        por = 1'h0, hx = 1'h0, hs = 1'h0, cal = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, d;
  logic [31:0] wdata = 32'h0, rdata, rw;
  logic        awready, wready, bvalid, arready, rvalid, xen, sysclk, xrst, wdr, low_voltage_reset, xpin;
  logic [1:0]  bresp, rresp, band, r;
  logic [2:0]  lvl;
  int          fails = 0, checks_done = 0, wd_cnt = 0, i;

  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (wdr) wd_cnt <= wd_cnt + 1;

  cssc_crystal_model xtal (.i_clk, .i_enable(xen), .o_pin(xpin));
  cssc_clock_control #(.WDT_LF_PERIODS(4), .LVR_SEL(3'h3)) dut (
    .i_clk, .i_reset_n, .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_crystal_pin_a(xpin), .i_reset_capable_pin(pin), .i_reset_pin_is_input(pin_in),
    .i_supply_low(sup_low), .i_power_on_done(por), .i_halt_exe(hx), .i_halt_sys(hs),
    .i_calibration_routine(cal), .o_crystal_enable(xen), .o_crystal_band(band),
    .o_sys_clk(sysclk), .o_external_reset(xrst), .o_watchdog_reset(wdr),
    .o_low_voltage_reset(low_voltage_reset), .o_lvr_level(lvl));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // the slave's answer is read at the edge where its valid is sampled high
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge i_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rw = rdata;
    d = rdata[7:0];
    r = rresp;
    rready <= 1'h0;
  endtask
  task automatic wait_idle;
    do rd(cssc_pkg::ADDR_STATUS);
    while (d[1] !== 1'h0);
  endtask
  task automatic rst;
    i_reset_n <= 1'h0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'h1;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic report_and_stop;
    if (fails == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #2000000;
    fails++;
    report_and_stop;
  end

  initial begin
    rst;
    rd(cssc_pkg::ADDR_CLOCK_MODE);
    chk("mode_rst", d, 8'h96);
    rd(cssc_pkg::ADDR_XTAL_CTRL);
    chk("xtal_rst", d, 8'h00);
    chk("lvr_level", lvl, 3'h3);
    rd(8'h20);
    chk("rd_unmapped", {r, rw[29:0]}, {cssc_pkg::RESP_SLVERR, 30'h0});
    wr(8'h20, 8'hff);
    chk("wr_unmapped", r, cssc_pkg::RESP_SLVERR);
    i = wd_cnt;
    repeat (2000) @(posedge i_clk);
    chk("wdog_default", wd_cnt > i, 1'h1);
    cal <= 1'h1;
    @(posedge i_clk);
    cal <= 1'h0;
    rd(cssc_pkg::ADDR_CLOCK_MODE);
    chk("wdog_cal_off", d, 8'h94);
    for (int b = 1; b < 4; b++) begin
      wr(cssc_pkg::ADDR_XTAL_CTRL, {1'h1, b[1:0], 5'h0});
      repeat (4) @(posedge i_clk);
      chk("xtal_en", xen, 1'h1);
      chk("band", band, b[1:0]);
    end
    rd(cssc_pkg::ADDR_STATUS);
    chk("not_stable", d[0], 1'h0);
    repeat (4300) @(posedge i_clk);
    rd(cssc_pkg::ADDR_STATUS);
    chk("stable", d[0], 1'h1);
    wr(cssc_pkg::ADDR_CLOCK_MODE, 8'h76);
    wait_idle;
    chk("src_xtal", d[6:4], cssc_pkg::SRC_XTAL);
    rst;
    wr(cssc_pkg::ADDR_CLOCK_MODE, 8'h36);
    wait_idle;
    chk("src_hf2", d[6:1], {cssc_pkg::SRC_HF_DIV2, 3'h2});
    wr(cssc_pkg::ADDR_CLOCK_MODE, 8'h32);
    rd(cssc_pkg::ADDR_CLOCK_MODE);
    chk("lf_off", d, 8'h32);
    i = wd_cnt;
    repeat (2000) @(posedge i_clk);
    chk("wdog_stopped", wd_cnt, i);
    rst;
    wr(cssc_pkg::ADDR_CLOCK_MODE, 8'h50);
    repeat (1000) @(posedge i_clk);
    rd(cssc_pkg::ADDR_STATUS);
    chk("hang_busy", d[1], 1'h1);
    chk("hang_clk", sysclk, 1'h0);
    rst;
    pin_in <= 1'h1;
    pin <= 1'h0;
    wr(cssc_pkg::ADDR_CLOCK_MODE, 8'h97);
    repeat (4) @(posedge i_clk);
    chk("ext_rst_on", xrst, 1'h1);
    pin <= 1'h1;
    repeat (4) @(posedge i_clk);
    chk("ext_rst_off", xrst, 1'h0);
    sup_low <= 1'h1;
    repeat (5) @(posedge i_clk);
    chk("lvr_pre_por", low_voltage_reset, 1'h0);
    por <= 1'h1;
    repeat (5) @(posedge i_clk);
    chk("lvr_on", low_voltage_reset, 1'h1);
    hx <= 1'h1;
    repeat (5) @(posedge i_clk);
    chk("lvr_halt_exe", low_voltage_reset, 1'h0);
    hx <= 1'h0;
    hs <= 1'h1;
    repeat (5) @(posedge i_clk);
    chk("lvr_halt_sys", low_voltage_reset, 1'h0);
    hs <= 1'h0;
    wr(cssc_pkg::ADDR_MISC_CTRL, 8'h04);
    repeat (5) @(posedge i_clk);
    chk("lvr_off", low_voltage_reset, 1'h0);
    report_and_stop;
  end
endmodule // clock_source_switch_control_test
